// ===== aftks_pkg.sv
// Shared constants, types and carriers of the frame type and key select block
package aftks_pkg;

  // Type/Len values that pick a frame type
  localparam logic [15:0] AFTKS_TL_IPV6      = 16'h86DD;
  localparam logic [15:0] AFTKS_TL_IPV4      = 16'h0800;
  localparam logic [15:0] AFTKS_TL_ARP       = 16'h0806;
  localparam logic [15:0] AFTKS_TL_RARP      = 16'h8035;
  localparam logic [15:0] AFTKS_TL_OAM       = 16'h8902;
  localparam logic [15:0] AFTKS_TL_PTP       = 16'h88F7;
  localparam logic [15:0] AFTKS_TL_GENERIC_ETHERTYPE_FRAME_MIN = 16'h0600;

  // IP header values
  localparam logic [3:0]  AFTKS_IP_VER6      = 4'h6;
  localparam logic [3:0]  AFTKS_IP_VER4      = 4'h4;
  localparam logic [7:0]  AFTKS_IPV6_MC_TOP  = 8'hFF;
  localparam logic [3:0]  AFTKS_IPV4_MC_TOP  = 4'hE;
  localparam logic [7:0]  AFTKS_PROTO_TCP    = 8'h06;
  localparam logic [7:0]  AFTKS_PROTO_UDP    = 8'h11;

  // LLC header values that mark SNAP
  localparam logic [7:0]  AFTKS_SAP_SNAP     = 8'hAA;
  localparam logic [7:0]  AFTKS_CTRL_SNAP    = 8'h03;

  // PTP over UDP destination ports and payload size
  localparam logic [15:0] AFTKS_PTP_EVENT    = 16'h013F;
  localparam logic [15:0] AFTKS_PTP_GENERAL  = 16'h0140;
  localparam int          AFTKS_PTP_BYTES    = 8;

  // Counts and widths
  localparam int          AFTKS_NUM_PORTS    = 53;
  localparam int          AFTKS_NUM_LOOKUPS  = 2;
  localparam int          AFTKS_PORT_W       = 6;

  // Selection codes, per port and lookup
  localparam logic [1:0]  AFTKS_V6MC_VLAN    = 2'h0;
  localparam logic [1:0]  AFTKS_V6MC_7TUP    = 2'h1;
  localparam logic [0:0]  AFTKS_V6UC_7TUP    = 1'h0;
  localparam logic [2:0]  AFTKS_V4MC_VLAN    = 3'h0;
  localparam logic [2:0]  AFTKS_V4MC_7TUP    = 3'h1;
  localparam logic [2:0]  AFTKS_V4MC_L4      = 3'h2;
  localparam logic [2:0]  AFTKS_V4MC_OTHER   = 3'h3;
  localparam logic [1:0]  AFTKS_V4UC_7TUP    = 2'h0;
  localparam logic [1:0]  AFTKS_V4UC_L4      = 2'h1;
  localparam logic [1:0]  AFTKS_V4UC_OTHER   = 2'h2;
  localparam logic [0:0]  AFTKS_ARP_KEY      = 1'h0;

  // Nine frame types
  typedef enum logic [3:0] {
    AFTKS_FT_IPV6_MC = 4'h0,
    AFTKS_FT_IPV6_UC = 4'h1,
    AFTKS_FT_IPV4_MC = 4'h2,
    AFTKS_FT_IPV4_UC = 4'h3,
    AFTKS_FT_ADDR_RES = 4'h4,
    AFTKS_FT_OAM     = 4'h5,
    AFTKS_FT_SNAP    = 4'h6,
    AFTKS_FT_LLC     = 4'h7,
    AFTKS_FT_GENERIC_ETHERTYPE_FRAME   = 4'h8
  } aftks_frame_type_t;

  // Layer 4 subtype of IP frames
  typedef enum logic [1:0] {
    AFTKS_L4_NONE  = 2'h0,
    AFTKS_L4_TCP   = 2'h1,
    AFTKS_L4_UDP   = 2'h2,
    AFTKS_L4_OTHER = 2'h3
  } aftks_l4_t;

  // Key types handed to the match memory
  typedef enum logic [2:0] {
    AFTKS_KEY_MAC_ETHERTYPE_KEY = 3'h0,
    AFTKS_KEY_ARP       = 3'h1,
    AFTKS_KEY_IPV4_VLAN = 3'h2,
    AFTKS_KEY_IPV4_L4   = 3'h3,
    AFTKS_KEY_IPV4_OTH  = 3'h4,
    AFTKS_KEY_7TUPLE    = 3'h5,
    AFTKS_KEY_IPV6_VLAN = 3'h6,
    AFTKS_KEY_CUSTOM    = 3'h7
  } aftks_key_t;

  // Parsed header fields of one frame
  typedef struct packed {
    logic [15:0]             type_len;    // Type/Len after tags
    logic [3:0]              ip_ver;      // IP version nibble
    logic [7:0]              ip_dst_top;  // Top byte of destination IP
    logic [7:0]              ip_proto;    // Protocol or next header
    logic [7:0]              dsap;        // LLC destination SAP
    logic [7:0]              ssap;        // LLC source SAP
    logic [7:0]              llc_ctrl;    // LLC control
    logic [15:0]             udp_dport;   // UDP destination port
    logic [63:0]             eth_pay;     // Bytes after EtherType
    logic [63:0]             udp_pay;     // Bytes after UDP header
    logic                    custom_ena;  // Upstream asks for custom key
    logic [1:0]              custom_pos;  // Upstream extraction point
    logic [AFTKS_PORT_W-1:0] port;        // Ingress port
  } aftks_frame_t;

  // Classification of one frame
  typedef struct packed {
    aftks_frame_type_t       frame_type;  // One of nine types
    aftks_l4_t               l4;          // IP subtype
    logic                    ptp;         // PTP encapsulation seen
    logic [63:0]             ptp_bytes;   // Extracted PTP payload
  } aftks_class_t;

  // Outcome of one lookup
  typedef struct packed {
    logic                    key_valid;   // Key is built
    aftks_key_t              key_type;    // Chosen key
    logic [1:0]              custom_pos;  // Point for custom key
  } aftks_lookup_t;

  // Key selection setting of one port and lookup
  typedef struct packed {
    logic [1:0]              v6mc;        // IPv6 multicast choice
    logic [0:0]              v6uc;        // IPv6 unicast choice
    logic [2:0]              v4mc;        // IPv4 multicast choice
    logic [1:0]              v4uc;        // IPv4 unicast choice
    logic [0:0]              arp;         // Address resolution choice
  } aftks_key_sel_t;

endpackage

// ===== aftks_classify.sv
// Combinational frame type, subtype and PTP classifier
module aftks_classify
(
  input  wire aftks_pkg::aftks_frame_t frm,  // Parsed frame fields
  output aftks_pkg::aftks_class_t      cls   // Classification
);
  import aftks_pkg::*;

  logic is_v6;  // IPv6 by Type/Len and version
  logic is_v4;  // IPv4 by Type/Len and version
  logic is_ptp_udp;  // UDP port of PTP

  // Sort the frame into one type
  always_comb
  begin
    cls   = '0;
    is_v6 = (frm.type_len == AFTKS_TL_IPV6) && (frm.ip_ver == AFTKS_IP_VER6);
    is_v4 = (frm.type_len == AFTKS_TL_IPV4) && (frm.ip_ver == AFTKS_IP_VER4);
    is_ptp_udp = (frm.udp_dport == AFTKS_PTP_EVENT) ||
                 (frm.udp_dport == AFTKS_PTP_GENERAL);
    if (is_v6)
    begin
      // Multicast prefix FF00::/8
      cls.frame_type = (frm.ip_dst_top == AFTKS_IPV6_MC_TOP) ?
                       AFTKS_FT_IPV6_MC : AFTKS_FT_IPV6_UC;  // RQ2
    end
    else if (is_v4)
    begin
      // Multicast prefix 224.0.0.0/4
      cls.frame_type = (frm.ip_dst_top[7:4] == AFTKS_IPV4_MC_TOP) ?
                       AFTKS_FT_IPV4_MC : AFTKS_FT_IPV4_UC;  // RQ4
    end
    else if ((frm.type_len == AFTKS_TL_ARP) ||
             (frm.type_len == AFTKS_TL_RARP))
    begin
      cls.frame_type = AFTKS_FT_ADDR_RES;  // RQ6
    end
    else if (frm.type_len == AFTKS_TL_OAM)
    begin
      cls.frame_type = AFTKS_FT_OAM;  // RQ7
    end
    else if (frm.type_len < AFTKS_TL_GENERIC_ETHERTYPE_FRAME_MIN)
    begin
      // Length field: LLC header decides
      if ((frm.dsap == AFTKS_SAP_SNAP) && (frm.ssap == AFTKS_SAP_SNAP) &&
          (frm.llc_ctrl == AFTKS_CTRL_SNAP))
        cls.frame_type = AFTKS_FT_SNAP;  // RQ8
      else
        cls.frame_type = AFTKS_FT_LLC;  // RQ9
    end
    else
    begin
      cls.frame_type = AFTKS_FT_GENERIC_ETHERTYPE_FRAME;  // RQ10
    end

    // IP subtype from protocol or next header
    if (is_v6 || is_v4)
    begin
      if (frm.ip_proto == AFTKS_PROTO_TCP)
        cls.l4 = AFTKS_L4_TCP;  // RQ3 RQ5
      else if (frm.ip_proto == AFTKS_PROTO_UDP)
        cls.l4 = AFTKS_L4_UDP;  // RQ3 RQ5
      else
        cls.l4 = AFTKS_L4_OTHER;  // RQ3 RQ5
    end

    // PTP over Ethernet or over UDP
    if (cls.frame_type == AFTKS_FT_GENERIC_ETHERTYPE_FRAME && frm.type_len == AFTKS_TL_PTP)
    begin
      cls.ptp       = 1'b1;  // RQ11
      cls.ptp_bytes = frm.eth_pay;  // RQ13
    end
    else if (cls.l4 == AFTKS_L4_UDP && is_ptp_udp)
    begin
      cls.ptp       = 1'b1;  // RQ12
      cls.ptp_bytes = frm.udp_pay;  // RQ13
    end
  end

endmodule

// ===== aftks_top.sv
// Frame type classification and per-lookup key selection
// Operation
// RQ1 - Every frame gets exactly one of nine types
// RQ2 - IPv6 typed multicast on FF00::/8 else unicast
// RQ3 - IPv6 subtype TCP, UDP or other
// RQ4 - IPv4 typed multicast on 224/4 else unicast
// RQ5 - IPv4 subtype TCP, UDP or other
// RQ6 - ARP and RARP give address resolution type
// RQ7 - Type/Len 0x8902 gives OAM type
// RQ8 - Length, SAPs 0xAA, control 0x3 give SNAP
// RQ9 - Other length frames are LLC
// RQ10 - Remaining EtherTypes are generic EtherType frames
// RQ11 - PTP over Ethernet is EtherType 0x88F7
// RQ12 - PTP over UDP uses ports 319, 320
// RQ13 - Extract eight PTP payload bytes
// RQ14 - Disabled lookup builds no key
// RQ15 - Key chosen per port, lookup, frame type
// RQ16 - OAM, SNAP, LLC, EtherType use MAC key
// RQ17 - Address resolution picks ARP or MAC key
// RQ18 - IPv6 keys allowed by multicast or unicast
// RQ19 - IPv4 keys allowed by multicast or unicast
// RQ20 - Upstream custom request overrides key selection
// RQ21 - One type per frame shared by lookups
module aftks_top
#(
  parameter int NUM_PORTS = aftks_pkg::AFTKS_NUM_PORTS  // Ingress ports
)
(
  input  wire logic                     sys_clk,  // Core clock
  input  wire logic                     rst,      // Sync reset
  input  wire logic                     frm_valid,  // Frame fields valid
  input  wire aftks_pkg::aftks_frame_t  frm,      // Parsed frame fields
  input  wire logic [NUM_PORTS-1:0][1:0] lookup_enable,  // Per port
  input  wire aftks_pkg::aftks_key_sel_t [NUM_PORTS-1:0][1:0]
                                        lookup_key_select,  // Per port
  output aftks_pkg::aftks_class_t       res_class_q,  // Frame class
  output logic [aftks_pkg::AFTKS_PORT_W-1:0] res_port_q,  // Ingress port
  output aftks_pkg::aftks_lookup_t [1:0] res_lookup_q,  // Lookup outcome
  output logic                          res_valid_q  // Result strobe
);
  import aftks_pkg::*;

  aftks_class_t            cls;           // Classifier output
  aftks_class_t            res_class_d;   // Next class
  aftks_lookup_t [1:0]     res_lookup_d;  // Next lookup outcome
  logic [AFTKS_PORT_W-1:0] res_port_d;    // Next port
  logic                    res_valid_d;   // Next strobe
  logic                    port_ok;       // Port within table

  // One classification per frame, shared by both lookups
  aftks_classify u_classify
  (
    .frm (frm),
    .cls (cls)
  );

  // Pick the key allowed for the frame type
  function automatic aftks_key_t select_key
  (
    input aftks_frame_type_t ft,
    input aftks_l4_t         l4,
    input aftks_key_sel_t    ks
  );
    aftks_key_t k;
    k = AFTKS_KEY_MAC_ETHERTYPE_KEY;
    case (ft)
      AFTKS_FT_IPV6_MC:
      begin
        if (ks.v6mc == AFTKS_V6MC_VLAN)
          k = AFTKS_KEY_IPV6_VLAN;  // RQ18
        else if (ks.v6mc == AFTKS_V6MC_7TUP)
          k = AFTKS_KEY_7TUPLE;  // RQ18
      end

      AFTKS_FT_IPV6_UC:
      begin
        if (ks.v6uc == AFTKS_V6UC_7TUP)
          k = AFTKS_KEY_7TUPLE;  // RQ18
      end

      AFTKS_FT_IPV4_MC:
      begin
        if (ks.v4mc == AFTKS_V4MC_VLAN)
          k = AFTKS_KEY_IPV4_VLAN;  // RQ19
        else if (ks.v4mc == AFTKS_V4MC_7TUP)
          k = AFTKS_KEY_7TUPLE;  // RQ19
        else if (ks.v4mc == AFTKS_V4MC_L4 && l4 != AFTKS_L4_OTHER)
          k = AFTKS_KEY_IPV4_L4;  // RQ19
        else if (ks.v4mc == AFTKS_V4MC_L4 ||
                 ks.v4mc == AFTKS_V4MC_OTHER)
          k = AFTKS_KEY_IPV4_OTH;  // RQ19
      end

      AFTKS_FT_IPV4_UC:
      begin
        if (ks.v4uc == AFTKS_V4UC_7TUP)
          k = AFTKS_KEY_7TUPLE;  // RQ19
        else if (ks.v4uc == AFTKS_V4UC_L4 && l4 != AFTKS_L4_OTHER)
          k = AFTKS_KEY_IPV4_L4;  // RQ19
        else if (ks.v4uc == AFTKS_V4UC_L4 ||
                 ks.v4uc == AFTKS_V4UC_OTHER)
          k = AFTKS_KEY_IPV4_OTH;  // RQ19
      end

      AFTKS_FT_ADDR_RES:
      begin
        if (ks.arp == AFTKS_ARP_KEY)
          k = AFTKS_KEY_ARP;  // RQ17
      end

      default:
      begin
        // OAM, SNAP, LLC and EtherType have one key only
        k = AFTKS_KEY_MAC_ETHERTYPE_KEY;  // RQ16
      end
    endcase
    return k;
  endfunction

  // Next result: class once, then each lookup on its own
  always_comb
  begin
    port_ok      = int'(frm.port) < NUM_PORTS;
    res_valid_d  = frm_valid;  // RQ21
    res_class_d  = res_class_q;
    res_port_d   = res_port_q;
    res_lookup_d = res_lookup_q;
    if (frm_valid)
    begin
      res_class_d = cls;  // RQ1
      res_port_d  = frm.port;
      for (int i = 0; i < AFTKS_NUM_LOOKUPS; i++)
      begin
        res_lookup_d[i] = '0;
        if (port_ok && lookup_enable[frm.port][i])
        begin
          res_lookup_d[i].key_valid = 1'b1;  // RQ14
          if (frm.custom_ena)
          begin
            // Upstream request wins over the port setting
            res_lookup_d[i].key_type   = AFTKS_KEY_CUSTOM;  // RQ20
            res_lookup_d[i].custom_pos = frm.custom_pos;  // RQ20
          end
          else
          begin
            res_lookup_d[i].key_type = select_key(cls.frame_type, cls.l4,
              lookup_key_select[frm.port][i]);  // RQ15 RQ21
          end
        end
      end
    end
  end

  // Result registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      res_valid_q  <= 1'b0;
      res_class_q  <= '0;
      res_port_q   <= '0;
      res_lookup_q <= '0;
    end
    else
    begin
      res_valid_q  <= res_valid_d;
      res_class_q  <= res_class_d;
      res_port_q   <= res_port_d;
      res_lookup_q <= res_lookup_d;
    end
  end

  // Checks on the result, one cycle after the frame
  logic en0;   // Lookup 0 enabled for this frame
  logic take;  // Frame taken; reset in the same edge drops it
  always_comb
  begin
    en0  = port_ok && lookup_enable[frm.port][0];
    take = frm_valid && !rst;
  end

  // Answer one edge later
  AST_RESULT_ONE_CYCLE: // RQ21
  assert property (@(posedge sys_clk) disable iff (rst)
    take |=> res_valid_q && res_class_q == $past(cls))
    else $error("Result did not follow frame by one cycle");

  // IPv6 multicast typing
  AST_IPV6_MC_TYPE: // RQ2
  assert property (@(posedge sys_clk) disable iff (rst)
    take && frm.type_len == AFTKS_TL_IPV6 &&
    frm.ip_ver == AFTKS_IP_VER6 && frm.ip_dst_top == AFTKS_IPV6_MC_TOP
    |=> res_class_q.frame_type == AFTKS_FT_IPV6_MC)
    else $error("IPv6 multicast frame mistyped");

  // IPv4 unicast typing
  AST_IPV4_UC_TYPE: // RQ4
  assert property (@(posedge sys_clk) disable iff (rst)
    take && frm.type_len == AFTKS_TL_IPV4 &&
    frm.ip_ver == AFTKS_IP_VER4 &&
    frm.ip_dst_top[7:4] != AFTKS_IPV4_MC_TOP
    |=> res_class_q.frame_type == AFTKS_FT_IPV4_UC)
    else $error("IPv4 unicast frame mistyped");

  // ARP and RARP typing
  AST_ADDR_RES_TYPE: // RQ6
  assert property (@(posedge sys_clk) disable iff (rst)
    take && (frm.type_len == AFTKS_TL_ARP ||
    frm.type_len == AFTKS_TL_RARP)
    |=> res_class_q.frame_type == AFTKS_FT_ADDR_RES)
    else $error("Address resolution frame mistyped");

  // SNAP typing
  AST_SNAP_TYPE: // RQ8
  assert property (@(posedge sys_clk) disable iff (rst)
    take && frm.type_len < AFTKS_TL_GENERIC_ETHERTYPE_FRAME_MIN &&
    frm.dsap == AFTKS_SAP_SNAP && frm.ssap == AFTKS_SAP_SNAP &&
    frm.llc_ctrl == AFTKS_CTRL_SNAP
    |=> res_class_q.frame_type == AFTKS_FT_SNAP)
    else $error("SNAP frame mistyped");

  // PTP on the event port
  AST_PTP_UDP: // RQ12
  assert property (@(posedge sys_clk) disable iff (rst)
    take && frm.type_len == AFTKS_TL_IPV4 &&
    frm.ip_ver == AFTKS_IP_VER4 && frm.ip_proto == AFTKS_PROTO_UDP &&
    frm.udp_dport == AFTKS_PTP_EVENT
    |=> res_class_q.ptp && res_class_q.ptp_bytes == $past(frm.udp_pay))
    else $error("PTP over UDP not recognised");

  // Disabled lookup stays off
  AST_DISABLED_NO_KEY: // RQ14
  assert property (@(posedge sys_clk) disable iff (rst)
    take && !en0 |=> !res_lookup_q[0].key_valid)
    else $error("Key built for disabled lookup");

  // Fixed key frame types
  AST_FIXED_MAC_KEY: // RQ16
  assert property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_lookup_q[1].key_valid &&
    res_lookup_q[1].key_type != AFTKS_KEY_CUSTOM &&
    res_class_q.frame_type inside {AFTKS_FT_OAM, AFTKS_FT_SNAP,
      AFTKS_FT_LLC, AFTKS_FT_GENERIC_ETHERTYPE_FRAME}
    |-> res_lookup_q[1].key_type == AFTKS_KEY_MAC_ETHERTYPE_KEY)
    else $error("Fixed frame type got a non MAC key");

  // No VLAN key on IPv6 unicast
  AST_UC_NO_VLAN_KEY: // RQ18
  assert property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_class_q.frame_type == AFTKS_FT_IPV6_UC
    |-> res_lookup_q[0].key_type != AFTKS_KEY_IPV6_VLAN)
    else $error("IPv6 unicast frame got the VLAN key");

  // Custom request wins
  AST_CUSTOM_OVERRIDE: // RQ20
  assert property (@(posedge sys_clk) disable iff (rst)
    take && en0 && frm.custom_ena
    |=> res_lookup_q[0].key_type == AFTKS_KEY_CUSTOM &&
        res_lookup_q[0].custom_pos == $past(frm.custom_pos))
    else $error("Custom request did not override selection");

  // Main scenarios
  COV_PTP_ETH: cover property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_class_q.ptp &&
    res_class_q.frame_type == AFTKS_FT_GENERIC_ETHERTYPE_FRAME);
  COV_V4MC_VLAN: cover property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_lookup_q[1].key_type == AFTKS_KEY_IPV4_VLAN);
  COV_SPLIT: cover property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_lookup_q[0].key_valid &&
    !res_lookup_q[1].key_valid);
  COV_ARP_KEY: cover property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_lookup_q[0].key_type == AFTKS_KEY_ARP);
  COV_CUSTOM: cover property (@(posedge sys_clk) disable iff (rst)
    res_valid_q && res_lookup_q[1].key_type == AFTKS_KEY_CUSTOM);

endmodule

// ===== aftks_parser_model.sv
// Upstream parser model that hands parsed frames to the block
module aftks_parser_model
(
  input  wire logic               sys_clk,    // Core clock
  output logic                    frm_valid,  // Frame strobe
  output aftks_pkg::aftks_frame_t frm         // Parsed fields
);
  timeunit 1ns;
  timeprecision 1ps;
  import aftks_pkg::*;

  // Quiet bus at time zero
  initial
  begin
    frm_valid = 1'b0;
    frm       = '0;
  end

  // Present one frame from the next edge, held until the next send or idle, one frame per cycle at most
  task automatic send(input aftks_frame_t f);
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm       <= f;
  endtask

  // Drop the strobe; invert the fields so stale use shows, which a second idle in a row undoes
  task automatic idle();
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    frm       <= ~frm;
  endtask
endmodule

// ===== test_aftks_top.sv
// Self-checking bench of the frame type and key select block
module test_aftks_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aftks_pkg::*;

  localparam int NP = 4;               // Small port count keeps tables short
  localparam int EW = NP * 2;          // Enable bits in total
  localparam int OW = $bits(aftks_class_t) + 6 + 2 * $bits(aftks_lookup_t);
  localparam logic [15:0] TL_TAB [12] = '{16'h86DD, 16'h0800, 16'h0806,
    16'h8035, 16'h8902, 16'h88F7, 16'h0000, 16'h05FF, 16'h0600, 16'h1234,
    16'h86DC, 16'h0801};
  localparam logic [3:0]  VER_TAB [3] = '{4'h4, 4'h6, 4'h5};
  localparam logic [7:0]  TOP_TAB [6] = '{8'hFF, 8'hFE, 8'hE0, 8'hEF,
    8'hF0, 8'hDF};
  localparam logic [7:0]  PRO_TAB [3] = '{8'h06, 8'h11, 8'h01};
  localparam logic [15:0] DP_TAB  [3] = '{16'h013F, 16'h0140, 16'h0141};

  logic                         sys_clk;            // Core clock
  logic                         rst;                // Sync reset
  logic                         frm_valid;          // From parser model
  aftks_frame_t                 frm;                // From parser model
  logic [NP-1:0][1:0]           lookup_enable;      // Per port enables
  aftks_key_sel_t [NP-1:0][1:0] lookup_key_select;  // Per port selects
  aftks_class_t                 res_class_q;        // Result class
  logic [AFTKS_PORT_W-1:0]      res_port_q;         // Result port
  aftks_lookup_t [1:0]          res_lookup_q;       // Result lookups
  logic                         res_valid_q;        // Result strobe
  logic                         got_rst;            // Reset seen at edge
  logic                         got_v;              // Frame taken at edge
  aftks_frame_t                 got_f;              // Frame taken
  logic [NP-1:0][1:0]           got_en;             // Enables taken
  aftks_key_sel_t [NP-1:0][1:0] got_ks;             // Selects taken
  logic [OW-1:0]                last;               // Outputs last cycle
  logic                         started;            // Hold check armed
  aftks_class_t                 ec;                 // Expected class
  aftks_class_t                 rc;                 // Seen class
  aftks_lookup_t                lk;                 // Seen lookup
  aftks_key_t                   ek;                 // Expected key
  logic                         on;                 // Lookup expected on
  int                           n_fail;             // Mismatches
  int                           checks_done;        // Comparisons
  int                           cycles;             // Timeout counter

  // Clock at 100 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  aftks_parser_model u_src
  (
    .sys_clk   (sys_clk),
    .frm_valid (frm_valid),
    .frm       (frm)
  );

  aftks_top #(.NUM_PORTS(NP)) DUT
  (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .frm_valid         (frm_valid),
    .frm               (frm),
    .lookup_enable     (lookup_enable),
    .lookup_key_select (lookup_key_select),
    .res_class_q       (res_class_q),
    .res_port_q        (res_port_q),
    .res_lookup_q      (res_lookup_q),
    .res_valid_q       (res_valid_q)
  );

  // Compare one value and count it
  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Reference classification of one frame
  function automatic aftks_class_t exp_class(input aftks_frame_t f);
    aftks_class_t c;
    logic         ip;
    c  = '0;
    ip = 1'b0;
    if (f.type_len == 16'h86DD && f.ip_ver == 4'h6)
    begin
      c.frame_type = (f.ip_dst_top == 8'hFF) ? AFTKS_FT_IPV6_MC
                                             : AFTKS_FT_IPV6_UC;
      ip = 1'b1;
    end
    else if (f.type_len == 16'h0800 && f.ip_ver == 4'h4)
    begin
      c.frame_type = (f.ip_dst_top[7:4] == 4'hE) ? AFTKS_FT_IPV4_MC
                                                 : AFTKS_FT_IPV4_UC;
      ip = 1'b1;
    end
    else if (f.type_len == 16'h0806 || f.type_len == 16'h8035)
      c.frame_type = AFTKS_FT_ADDR_RES;
    else if (f.type_len == 16'h8902)
      c.frame_type = AFTKS_FT_OAM;
    else if (f.type_len < 16'h0600)
      c.frame_type = (f.dsap == 8'hAA && f.ssap == 8'hAA &&
                      f.llc_ctrl == 8'h03) ? AFTKS_FT_SNAP : AFTKS_FT_LLC;
    else
      c.frame_type = AFTKS_FT_GENERIC_ETHERTYPE_FRAME;
    // IP subtype from protocol or next header
    if (ip)
      c.l4 = (f.ip_proto == 8'h06) ? AFTKS_L4_TCP :
             (f.ip_proto == 8'h11) ? AFTKS_L4_UDP : AFTKS_L4_OTHER;
    // PTP over Ethernet or over UDP event and general ports
    if (c.frame_type == AFTKS_FT_GENERIC_ETHERTYPE_FRAME && f.type_len == 16'h88F7)
    begin
      c.ptp       = 1'b1;
      c.ptp_bytes = f.eth_pay;
    end
    else if (c.l4 == AFTKS_L4_UDP &&
             (f.udp_dport == 16'h013F || f.udp_dport == 16'h0140))
    begin
      c.ptp       = 1'b1;
      c.ptp_bytes = f.udp_pay;
    end
    return c;
  endfunction

  // Reference key choice for an enabled lookup without custom request
  function automatic aftks_key_t exp_key(input aftks_class_t c,
                                         input aftks_key_sel_t s);
    aftks_key_t k;
    logic       oth;
    k   = AFTKS_KEY_MAC_ETHERTYPE_KEY;
    oth = (c.l4 == AFTKS_L4_OTHER);
    case (c.frame_type)
      AFTKS_FT_IPV6_MC:
        if (s.v6mc == 2'h0)
          k = AFTKS_KEY_IPV6_VLAN;
        else if (s.v6mc == 2'h1)
          k = AFTKS_KEY_7TUPLE;
      AFTKS_FT_IPV6_UC:
        if (s.v6uc == 1'h0)
          k = AFTKS_KEY_7TUPLE;
      AFTKS_FT_IPV4_MC:
        case (s.v4mc)
          3'h0:    k = AFTKS_KEY_IPV4_VLAN;
          3'h1:    k = AFTKS_KEY_7TUPLE;
          3'h2:    k = oth ? AFTKS_KEY_IPV4_OTH : AFTKS_KEY_IPV4_L4;
          3'h3:    k = AFTKS_KEY_IPV4_OTH;
          default: k = AFTKS_KEY_MAC_ETHERTYPE_KEY;
        endcase
      AFTKS_FT_IPV4_UC:
        case (s.v4uc)
          2'h0:    k = AFTKS_KEY_7TUPLE;
          2'h1:    k = oth ? AFTKS_KEY_IPV4_OTH : AFTKS_KEY_IPV4_L4;
          2'h2:    k = AFTKS_KEY_IPV4_OTH;
          default: k = AFTKS_KEY_MAC_ETHERTYPE_KEY;
        endcase
      AFTKS_FT_ADDR_RES:
        if (s.arp == 1'h0)
          k = AFTKS_KEY_ARP;
      default: k = AFTKS_KEY_MAC_ETHERTYPE_KEY;
    endcase
    return k;
  endfunction

  // Random frame biased toward the values that decide the type
  function automatic aftks_frame_t rnd_frame();
    aftks_frame_t f;
    f.type_len   = TL_TAB[$urandom_range(11)];
    f.ip_ver     = VER_TAB[$urandom_range(2)];
    f.ip_dst_top = TOP_TAB[$urandom_range(5)];
    f.ip_proto   = PRO_TAB[$urandom_range(2)];
    f.dsap       = $urandom_range(1) ? 8'hAA : 8'hAB;
    f.ssap       = $urandom_range(1) ? 8'hAA : 8'h2A;
    f.llc_ctrl   = $urandom_range(1) ? 8'h03 : 8'h13;
    f.udp_dport  = DP_TAB[$urandom_range(2)];
    f.eth_pay    = {$urandom, $urandom};
    f.udp_pay    = {$urandom, $urandom};
    f.custom_ena = ($urandom_range(3) == 0);
    f.custom_pos = 2'($urandom);
    f.port       = 6'($urandom_range(NP + 1));
    return f;
  endfunction

  // New enables and selects for every port, taken with the next frame
  task automatic drive_cfg();
    aftks_key_sel_t [NP-1:0][1:0] ks;
    for (int p = 0; p < NP; p++)
      for (int l = 0; l < 2; l++)
        ks[p][l] = 9'($urandom);
    lookup_enable     <= EW'($urandom);
    lookup_key_select <= ks;
  endtask

  // Record what the block takes at each edge; cut a hang short
  always @(posedge sys_clk)
  begin
    got_rst <= rst;
    got_v   <= frm_valid;
    got_f   <= frm;
    got_en  <= lookup_enable;
    got_ks  <= lookup_key_select;
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Compare settled outputs with the reference at the falling edge after taking
  always @(negedge sys_clk)
  begin
    rc = res_class_q;
    if (got_rst)
    begin
      check("rst_valid", res_valid_q, 1'b0);
      check("rst_out", {res_class_q, res_port_q, res_lookup_q}, '0);
    end
    else if (got_v)
    begin
      ec = exp_class(got_f);
      check("valid", res_valid_q, 1'b1);
      check("ftype", rc.frame_type, ec.frame_type);
      check("class", rc, ec);
      check("l4", rc.l4, ec.l4);
      check("ptp", rc.ptp, ec.ptp);
      check("ptp_bytes", rc.ptp_bytes, ec.ptp_bytes);
      check("port", res_port_q, got_f.port);
      for (int i = 0; i < 2; i++)
      begin
        lk = res_lookup_q[i];
        on = 1'b0;
        if (got_f.port < NP)
          on = got_en[got_f.port][i];
        check("key_valid", lk.key_valid, on);
        if (on && got_f.custom_ena)
        begin
          check("custom", lk.key_type, AFTKS_KEY_CUSTOM);
          check("custom_pos", lk.custom_pos, got_f.custom_pos);
        end
        else if (on)
        begin
          ek = exp_key(ec, got_ks[got_f.port][i]);
          check("key_type", lk.key_type, ek);
        end
      end
    end
    else if (started)
    begin
      check("idle_valid", res_valid_q, 1'b0);
      check("hold", {res_class_q, res_port_q, res_lookup_q}, last);
    end
    last    = {res_class_q, res_port_q, res_lookup_q};
    started = 1'b1;
  end

  // Main sequence: reset, random back-to-back traffic, reset mid-run
  initial
  begin
    rst               = 1'b1;
    lookup_enable     = '0;
    lookup_key_select = '0;
    got_rst           = 1'b0;
    got_v             = 1'b0;
    started           = 1'b0;
    n_fail            = 0;
    checks_done       = 0;
    cycles            = 0;
    void'($urandom(42));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    u_src.idle();
    for (int n = 0; n < 1500; n++)
    begin
      if (n == 700)
      begin
        u_src.send(rnd_frame());
        rst <= 1'b1;
        u_src.idle();
        rst <= 1'b0;
        u_src.idle();
      end
      if ($urandom_range(3) == 0)
        u_src.idle();
      else
        u_src.send(rnd_frame());
      drive_cfg();
    end
    u_src.idle();
    repeat (3) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule
